// file: hdl/hmc_pkg.sv
// constants and types for the host misc register slice and mac bridge
// Notes on behaviour
// R1: timer count read-only low half, ones default
// R2: 32-bit bus ignores halfword order control
// R3: 16-bit non-swap: address bit1 high selects high
// R4: 16-bit swap pattern: address bit1 high selects low
// R5: network halfword order always low first
// R6: 32-bit tick counter counts 25MHz, wraps
// R7: 16-bit read of tick count uses snapshot
// R8: tick counter zero within 160ns of reset
// R9: tick counter never halts in low power
// R10: drop counter counts discards, clears on read
// R11: event when drop counter crosses midpoint
// R12: busy bit starts operation, self-clears when done
// R13: read data valid once busy clears
// R14: host must not write while busy
// R15: direction bit set means read, clear write
// R16: low byte selects target mac register
// R17: data register r/w, zero default, both ways
// R18: bridge signals completion only after transfer ends
// R19: drop during clearing read is still counted
package hmc_pkg;
   localparam logic [7:0] OFS_TIMER = 8'h90;
   localparam logic [7:0] OFS_ORDER = 8'h98;
   localparam logic [7:0] OFS_TICK = 8'h9C;
   localparam logic [7:0] OFS_DROP = 8'hA0;
   localparam logic [7:0] OFS_CMD = 8'hA4;
   localparam logic [7:0] OFS_DATA = 8'hA8;
   localparam logic [15:0] TIMER_RST = 16'hFFFF;
   localparam logic [31:0] ORDER_RST = 32'h0000_0000;
   localparam logic [31:0] SWAP_PATTERN = 32'hFFFF_FFFF;
   localparam logic [31:0] DROP_RST = 32'h0000_0000;
   localparam logic [31:0] DROP_HALF = 32'h8000_0000;
   localparam logic [31:0] DATA_RST = 32'h0000_0000;
   localparam logic [31:0] TICK_RST = 32'h0000_0000;
   localparam int CMD_BUSY_BIT = 31;
   localparam int CMD_RNW_BIT = 30;
   localparam int CMD_ADDR_W = 8;
   localparam int CLK_MHZ = 100;
   localparam int TICK_MHZ = 25;
   localparam int TICK_DIV = CLK_MHZ / TICK_MHZ;
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_CLEAR_NS = 160;
   localparam int TICK_CLEAR_CYC = TICK_CLEAR_NS / CLK_PERIOD_NS;
   typedef enum logic {BRG_IDLE, BRG_WAIT} hmc_brg_st_t;
endpackage

// file: hdl/hmc_tick_div.sv
// divider making the one-cycle 25MHz tick enable from the system clock
`timescale 1ns/1ps
module hmc_tick_div
   import hmc_pkg::*;
#(
   parameter int DIV = TICK_DIV
)
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   output logic tick_o
);
   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   logic [CW-1:0] cnt_r;

   // refuse a divider that cannot make a tick at all
   if (DIV < 1)
   begin : g_bad_div
      $error("tick divider must be at least one");
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         cnt_r <= '0;
         tick_o <= 1'b0;
      end
      else
      begin
         tick_o <= (cnt_r == LAST);
         cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
      end
   end
endmodule

// file: hdl/hmc_csr_top.sv
// host misc registers: timer view, halfword order, tick, drops, mac bridge
`timescale 1ns/1ps
module hmc_csr_top
   import hmc_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic bus16_i,
   input wire logic cs_i,
   input wire logic rd_i,
   input wire logic wr_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   output logic [31:0] rdata_o,
   input wire logic [15:0] timer_current_value_i,
   input wire logic frame_drop_i,
   output logic drop_half_o,
   output logic mac_req_o,
   output logic mac_read_not_write_o,
   output logic [7:0] mac_addr_o,
   output logic [31:0] mac_wdata_o,
   input wire logic mac_ack_i,
   input wire logic [31:0] mac_rdata_i,
   input wire logic [31:0] tx_word_i,
   input wire logic tx_word_valid_i,
   output logic tx_word_ready_o,
   output logic [15:0] tx_half_o,
   output logic tx_half_valid_o,
   input wire logic [15:0] rx_half_i,
   input wire logic rx_half_valid_i,
   output logic [31:0] rx_word_o,
   output logic rx_word_valid_o
);
   // halfword selection for the addressed access
   function automatic logic hi_sel(input logic a1, input logic [31:0] ord);
      // R4: swap pattern inverts address bit 1
      if (ord == SWAP_PATTERN)
         return ~a1;
      // R3: any other value keeps bit 1 as is
      return a1;
   endfunction

   // merge a host write into a register image
   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] wd, input logic b16, input logic hi);
      // R2: 32-bit bus writes the whole word as placed
      if (!b16)
         return wd;
      if (hi)
         return {wd[15:0], old[15:0]};
      return {old[31:16], wd[15:0]};
   endfunction

   // pick the data returned for a register image
   function automatic logic [31:0] pick(input logic [31:0] val,
      input logic b16, input logic hi);
      if (!b16)
         return val;
      return {16'h0000, hi ? val[31:16] : val[15:0]};
   endfunction

   logic [7:0] word_addr;
   logic rd_stb;
   logic wr_stb;
   logic hi;
   logic tick;
   logic [31:0] order_r;
   logic [31:0] tick_cnt_r;
   logic [31:0] tick_snap_r;
   logic tick_held_r;
   logic [31:0] drop_cnt_r;
   logic [31:0] drop_base;
   logic [31:0] drop_nxt;
   logic drop_clr;
   hmc_brg_st_t brg_st_r;
   logic busy_r;
   logic rnw_r;
   logic [CMD_ADDR_W-1:0] csr_addr_r;
   logic [31:0] data_r;
   logic [31:0] cmd_view;
   logic [31:0] cmd_nxt;
   logic cmd_wr;
   logic data_wr;
   logic [31:0] rd_val;
   logic [15:0] tx_hold_r;
   logic tx_pend_r;
   logic [15:0] rx_low_r;
   logic rx_have_r;

   assign word_addr = {addr_i[7:2], 2'b00};
   assign rd_stb = cs_i & rd_i;
   assign wr_stb = cs_i & wr_i;
   assign hi = hi_sel(addr_i[1], order_r);

   hmc_tick_div #(
      .DIV(TICK_DIV)
   ) u_div (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .tick_o(tick)
   );

   // the address field must match the mac address port and stay below rnw
   if (CMD_ADDR_W != 8 || CMD_RNW_BIT <= CMD_ADDR_W)
   begin : g_bad_cmd
      $error("command field layout does not fit the ports");
   end

   // halfword order control
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         order_r <= ORDER_RST;
      else if (wr_stb && word_addr == OFS_ORDER)
         order_r <= merge(order_r, wdata_i, bus16_i, hi);
   end

   // free-running tick counter; no power state gates it
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      // R8: async reset clears at once, well inside the bound
      if (sys_rst_i)
         tick_cnt_r <= TICK_RST;
      // R6: count each 25MHz tick, natural wrap
      // R9: no low-power enable on the increment
      else if (tick)
         tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
   end

   // R7: first halfword read latches the whole count
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         tick_snap_r <= TICK_RST;
         tick_held_r <= 1'b0;
      end
      else if (rd_stb && bus16_i && word_addr == OFS_TICK)
      begin
         if (!tick_held_r)
            tick_snap_r <= tick_cnt_r;
         tick_held_r <= ~tick_held_r;
      end
      // a 32-bit read abandons a half-finished pair, so no stale
      // snapshot is served afterwards
      else if (rd_stb && word_addr == OFS_TICK)
         tick_held_r <= 1'b0;
   end

   // R10: any read of the drop counter clears it
   assign drop_clr = rd_stb && word_addr == OFS_DROP;
   assign drop_base = drop_clr ? DROP_RST : drop_cnt_r;
   // R19: a drop in the clearing cycle lands after the clear
   assign drop_nxt = drop_base + {31'h0000_0000, frame_drop_i};

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         drop_cnt_r <= DROP_RST;
      else
         drop_cnt_r <= drop_nxt;
   end

   // R11: pulse on the step into the midpoint value
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         drop_half_o <= 1'b0;
      else
         drop_half_o <= frame_drop_i && (drop_nxt == DROP_HALF);
   end

   // command image as the host sees it
   always_comb
   begin
      cmd_view = 32'h0000_0000;
      cmd_view[CMD_BUSY_BIT] = busy_r;
      cmd_view[CMD_RNW_BIT] = rnw_r;
      cmd_view[CMD_ADDR_W-1:0] = csr_addr_r;
   end

   // writes while busy are dropped so the transfer stays coherent
   assign cmd_wr = wr_stb && word_addr == OFS_CMD && !busy_r;
   assign data_wr = wr_stb && word_addr == OFS_DATA && !busy_r;
   assign cmd_nxt = merge(cmd_view, wdata_i, bus16_i, hi);

   // mac bridge sequencer
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         brg_st_r <= BRG_IDLE;
         busy_r <= 1'b0;
         rnw_r <= 1'b0;
         csr_addr_r <= '0;
         mac_req_o <= 1'b0;
         mac_read_not_write_o <= 1'b0;
         mac_addr_o <= '0;
         mac_wdata_o <= DATA_RST;
      end
      else
      begin
         unique case (brg_st_r)
            BRG_IDLE:
            begin
               if (cmd_wr)
               begin
                  rnw_r <= cmd_nxt[CMD_RNW_BIT];
                  csr_addr_r <= cmd_nxt[CMD_ADDR_W-1:0];
                  // R12: writing busy one launches the access
                  if (cmd_nxt[CMD_BUSY_BIT])
                  begin
                     busy_r <= 1'b1;
                     brg_st_r <= BRG_WAIT;
                     mac_req_o <= 1'b1;
                     // R15: direction bit set is a read
                     mac_read_not_write_o <= cmd_nxt[CMD_RNW_BIT];
                     // R16: low byte picks the mac register
                     mac_addr_o <= cmd_nxt[CMD_ADDR_W-1:0];
                     mac_wdata_o <= data_r;
                  end
               end
            end
            BRG_WAIT:
            begin
               // R18: busy drops only with the far end's ack
               if (mac_ack_i)
               begin
                  mac_req_o <= 1'b0;
                  busy_r <= 1'b0;
                  brg_st_r <= BRG_IDLE;
               end
            end
         endcase
      end
   end

   // R17: data register, host written or mac loaded
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         data_r <= DATA_RST;
      // R13: read data is in place as busy clears
      else if (brg_st_r == BRG_WAIT && mac_ack_i && rnw_r)
         data_r <= mac_rdata_i;
      // R14: host writes during busy are ignored here
      else if (data_wr)
         data_r <= merge(data_r, wdata_i, bus16_i, hi);
   end

   // read data selection
   always_comb
   begin
      rd_val = 32'h0000_0000;
      unique case (word_addr)
         // R1: timer count in low half, upper reserved zero
         OFS_TIMER:
            rd_val = pick({16'h0000, timer_current_value_i}, bus16_i, hi);
         OFS_ORDER:
            rd_val = pick(order_r, bus16_i, hi);
         OFS_TICK:
            rd_val = pick((tick_held_r && bus16_i) ? tick_snap_r : tick_cnt_r,
               bus16_i, hi);
         OFS_DROP:
            rd_val = pick(drop_cnt_r, bus16_i, hi);
         OFS_CMD:
            rd_val = pick(cmd_view, bus16_i, hi);
         OFS_DATA:
            rd_val = pick(data_r, bus16_i, hi);
         default:
            rd_val = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         rdata_o <= 32'h0000_0000;
      else if (rd_stb)
         rdata_o <= rd_val;
   end

   // R5: transmit word leaves low halfword first
   // ready drops for the low-half cycle so no word is taken mid-pair
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         tx_hold_r <= 16'h0000;
         tx_pend_r <= 1'b0;
         tx_half_o <= 16'h0000;
         tx_half_valid_o <= 1'b0;
         tx_word_ready_o <= 1'b0;
      end
      else if (tx_word_valid_i && tx_word_ready_o)
      begin
         tx_half_o <= tx_word_i[15:0];
         tx_hold_r <= tx_word_i[31:16];
         tx_half_valid_o <= 1'b1;
         tx_pend_r <= 1'b1;
         tx_word_ready_o <= 1'b0;
      end
      else if (tx_pend_r)
      begin
         tx_half_o <= tx_hold_r;
         tx_half_valid_o <= 1'b1;
         tx_pend_r <= 1'b0;
         tx_word_ready_o <= 1'b1;
      end
      else
      begin
         tx_half_valid_o <= 1'b0;
         tx_word_ready_o <= 1'b1;
      end
   end

   // R5: first received halfword fills the low half
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         rx_low_r <= 16'h0000;
         rx_have_r <= 1'b0;
         rx_word_o <= 32'h0000_0000;
         rx_word_valid_o <= 1'b0;
      end
      else if (rx_half_valid_i && !rx_have_r)
      begin
         rx_low_r <= rx_half_i;
         rx_have_r <= 1'b1;
         rx_word_valid_o <= 1'b0;
      end
      else if (rx_half_valid_i)
      begin
         rx_word_o <= {rx_half_i, rx_low_r};
         rx_have_r <= 1'b0;
         rx_word_valid_o <= 1'b1;
      end
      else
         rx_word_valid_o <= 1'b0;
   end
endmodule

// file: tb/hmc_csr_assertions.sv
// assertion checker for the host misc register slice
`timescale 1ns/1ps
module hmc_csr_assertions
   import hmc_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic bus16_i,
   input wire logic cs_i,
   input wire logic rd_i,
   input wire logic wr_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic [31:0] rdata_o,
   input wire logic [15:0] timer_current_value_i,
   input wire logic frame_drop_i,
   input wire logic drop_half_o,
   input wire logic mac_req_o,
   input wire logic mac_read_not_write_o,
   input wire logic [7:0] mac_addr_o,
   input wire logic mac_ack_i,
   input wire logic [31:0] tx_word_i,
   input wire logic tx_word_valid_i,
   input wire logic tx_word_ready_o,
   input wire logic [15:0] tx_half_o,
   input wire logic tx_half_valid_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   wire go = cs_i && wr_i && !bus16_i && addr_i == OFS_CMD && wdata_i[31];
   wire txa = tx_word_valid_i && tx_word_ready_o;
   chk_req_start: assert property (go && !mac_req_o |=> mac_req_o
      && mac_addr_o == $past(wdata_i[7:0])
      && mac_read_not_write_o == $past(wdata_i[30]))
      else $error("request fields wrong");
   chk_req_hold: assert property (mac_req_o && !mac_ack_i |=> mac_req_o
      && $stable(mac_addr_o) && $stable(mac_read_not_write_o))
      else $error("request not held");
   chk_req_end: assert property (mac_req_o && mac_ack_i |=> !mac_req_o)
      else $error("request outlives ack");
   chk_no_stray: assert property (!mac_req_o && !(cs_i && wr_i)
      |=> !mac_req_o) else $error("request without command");
   chk_timer_view: assert property (cs_i && rd_i && !bus16_i
      && addr_i == OFS_TIMER
      |=> rdata_o == {16'h0000, $past(timer_current_value_i)})
      else $error("timer view wrong");
   chk_tx_low: assert property (txa |=> tx_half_valid_o
      && !tx_word_ready_o && tx_half_o == $past(tx_word_i[15:0]))
      else $error("low half not first");
   chk_tx_high: assert property (txa |=> ##1 tx_half_valid_o
      && tx_half_o == $past(tx_word_i[31:16], 2))
      else $error("high half not second");
   chk_half_pulse: assert property (drop_half_o |=> !drop_half_o)
      else $error("midpoint event too long");
   chk_half_cause: assert property (!frame_drop_i |=> !drop_half_o)
      else $error("midpoint event without drop");
   cover property (mac_req_o && mac_ack_i && mac_read_not_write_o);
   cover property (go);
   cover property (txa);
endmodule
bind hmc_csr_top hmc_csr_assertions u_chk (.*);

// file: tb/hmc_mac_model.sv
// behavioural model of the mac register space behind the bridge
`timescale 1ns/1ps
module hmc_mac_model
(
   input wire logic clk_i,
   input wire logic req_i,
   input wire logic rnw_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] lat_i,
   output logic ack_o,
   output logic [31:0] rdata_o
);
   logic [31:0] mem_r [256];
   logic [3:0] cnt_r = 4'h0;
   initial ack_o = 1'b0;
   initial rdata_o = 32'h0;
   always @(posedge clk_i)
   begin
      ack_o <= 1'b0;
      // data lines carry junk outside the ack cycle
      rdata_o <= ~rdata_o;
      if (req_i && !ack_o)
      begin
         cnt_r <= cnt_r + 4'h1;
         if (cnt_r == lat_i)
         begin
            ack_o <= 1'b1;
            cnt_r <= 4'h0;
            if (rnw_i)
               rdata_o <= mem_r[addr_i];
            else
               mem_r[addr_i] <= wdata_i;
         end
      end
   end
endmodule

// file: tb/tb.sv
// self-checking bench for the host misc register slice
`timescale 1ns/1ps
module tb import hmc_pkg::*;;
   logic clk_i = 1'b0, sys_rst_i = 1'b1, bus16_i = 1'b0, cs_i = 1'b0;
   logic rd_i = 1'b0, wr_i = 1'b0, frame_drop_i = 1'b0, dr = 1'b0;
   logic tx_word_valid_i = 1'b0, rx_half_valid_i = 1'b0, mac_ack_i;
   logic [7:0] addr_i = 8'h00, mac_addr_o;
   logic [31:0] wdata_i = 32'h0, tx_word_i = 32'h0, mac_rdata_i;
   logic [31:0] rdata_o, rx_word_o, mac_wdata_o, v, w;
   logic [15:0] timer_current_value_i = 16'hFFFF, rx_half_i = 16'h0;
   logic [15:0] tx_half_o;
   logic drop_half_o, mac_req_o, mac_read_not_write_o, tx_word_ready_o;
   logic tx_half_valid_o, rx_word_valid_o;
   logic [3:0] lat = 4'h0;
   int fails = 0, checks_done = 0;
   always #5 clk_i = ~clk_i;
   hmc_csr_top dut (.*);
   hmc_mac_model mac (.clk_i(clk_i), .req_i(mac_req_o),
      .rnw_i(mac_read_not_write_o), .addr_i(mac_addr_o),
      .wdata_i(mac_wdata_o), .lat_i(lat), .ack_o(mac_ack_i),
      .rdata_o(mac_rdata_i));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // one strobe cycle; dr adds a frame drop in the same cycle
   task acc(input logic r, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cs_i <= 1'b1;
      rd_i <= r;
      wr_i <= !r;
      addr_i <= a;
      wdata_i <= d;
      frame_drop_i <= dr;
      @(posedge clk_i);
      cs_i <= 1'b0;
      rd_i <= 1'b0;
      wr_i <= 1'b0;
      frame_drop_i <= 1'b0;
      #1 v = rdata_o;
   endtask
   task rc(input logic [7:0] a, input logic [31:0] exp);
      acc(1'b1, a, 32'h0);
      chk(v, exp);
   endtask
   task mode(input logic b);
      @(posedge clk_i);
      bus16_i <= b;
   endtask
   task wait_idle;
      v = 32'hFFFF_FFFF;
      for (int i = 0; i < 40 && v[31] !== 1'b0; i++)
         acc(1'b1, OFS_CMD, 32'h0);
      chk(v & 32'h8000_0000, 32'h0);
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      #100000;
      fails++;
      report_and_stop;
   end
   initial
   begin
      repeat (4) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      rc(OFS_TICK, 32'h0);
      rc(OFS_TIMER, 32'h0000_FFFF);
      rc(OFS_ORDER, 32'h0);
      rc(OFS_DATA, 32'h0);
      rc(8'h94, 32'h0);
      $display("end reset values");
      acc(1'b1, OFS_TICK, 32'h0);
      w = v;
      repeat (38) @(posedge clk_i);
      rc(OFS_TICK, w + 32'd10);
      mode(1'b1);
      acc(1'b1, OFS_TICK, 32'h0);
      w = v;
      repeat (20) @(posedge clk_i);
      rc(OFS_TICK, w);
      $display("end tick");
      acc(1'b0, OFS_DATA, 32'h1234);
      acc(1'b0, 8'hAA, 32'h5678);
      acc(1'b0, OFS_ORDER, 32'hFFFF);
      acc(1'b0, 8'h9A, 32'hFFFF);
      acc(1'b0, OFS_DATA, 32'h00AB);
      mode(1'b0);
      rc(OFS_ORDER, SWAP_PATTERN);
      rc(OFS_DATA, 32'h00AB_1234);
      acc(1'b0, OFS_DATA, 32'hAABB_CCDD);
      rc(OFS_DATA, 32'hAABB_CCDD);
      acc(1'b0, OFS_ORDER, 32'h0);
      $display("end halfword order");
      dr = 1'b1;
      repeat (3) acc(1'b0, 8'h94, 32'h0);
      rc(OFS_DROP, 32'd3);
      dr = 1'b0;
      rc(OFS_DROP, 32'd1);
      rc(OFS_DROP, 32'd0);
      $display("end drops");
      lat = 4'd9;
      acc(1'b0, OFS_DATA, 32'hDEAD_BEEF);
      acc(1'b0, OFS_CMD, 32'h8000_0012);
      chk(mac_wdata_o, 32'hDEAD_BEEF);
      w = {22'h000000, mac_req_o, mac_read_not_write_o, mac_addr_o};
      chk(w, 32'h0000_0212);
      acc(1'b1, OFS_CMD, 32'h0);
      chk(v & 32'hC000_00FF, 32'h8000_0012);
      acc(1'b0, OFS_DATA, 32'h0);
      wait_idle;
      rc(OFS_DATA, 32'hDEAD_BEEF);
      acc(1'b0, OFS_DATA, 32'h0);
      lat = 4'd0;
      acc(1'b0, OFS_CMD, 32'hC000_0012);
      w = {22'h000000, mac_req_o, mac_read_not_write_o, mac_addr_o};
      chk(w, 32'h0000_0312);
      wait_idle;
      rc(OFS_DATA, 32'hDEAD_BEEF);
      $display("end mac bridge");
      @(posedge clk_i);
      tx_word_i <= 32'h2222_1111;
      tx_word_valid_i <= 1'b1;
      rx_half_i <= 16'hAAAA;
      rx_half_valid_i <= 1'b1;
      @(posedge clk_i);
      tx_word_valid_i <= 1'b0;
      rx_half_i <= 16'hBBBB;
      #1 chk({16'h0000, tx_half_o}, 32'h0000_1111);
      @(posedge clk_i);
      rx_half_valid_i <= 1'b0;
      rx_half_i <= 16'h5A5A;
      #1;
      chk({16'h0000, tx_half_o}, 32'h0000_2222);
      for (int i = 0; i < 5 && rx_word_valid_o !== 1'b1; i++)
         @(posedge clk_i) #1;
      chk(rx_word_o, 32'hBBBB_AAAA);
      repeat (3) @(posedge clk_i);
      $display("end network order");
      @(posedge clk_i);
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      rc(OFS_TICK, 32'h0);
      rc(OFS_DATA, 32'h0);
      $display("end mid-run reset");
      report_and_stop;
   end
endmodule
